// File: rpc_pkg.sv
/*
 * Shared constants for the rail protection configuration register bank:
 * register indices and byte addresses, field positions, reset values,
 * unlock key and the voltage scale figures of the buck rails.
 * Assumes an APB slave with 32-bit data and one aligned word per register.
 */
package rpc_pkg;

    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0]  RPC_IDX_FB_RATIO   = 8'h76;
    localparam logic [7:0]  RPC_IDX_OV_DIS     = 8'h77;
    localparam logic [7:0]  RPC_IDX_UV_DIS     = 8'h78;
    localparam logic [7:0]  RPC_IDX_OC_DIS     = 8'h79;
    localparam logic [7:0]  RPC_IDX_FAULT_REC  = 8'h7D;
    localparam logic [7:0]  RPC_IDX_UNLOCK     = 8'h7E;

    localparam int          RPC_ADDR_W         = 12;
    localparam logic [11:0] RPC_ADDR_FB_RATIO  = {2'h0, RPC_IDX_FB_RATIO, 2'h0};
    localparam logic [11:0] RPC_ADDR_OV_DIS    = {2'h0, RPC_IDX_OV_DIS, 2'h0};
    localparam logic [11:0] RPC_ADDR_UV_DIS    = {2'h0, RPC_IDX_UV_DIS, 2'h0};
    localparam logic [11:0] RPC_ADDR_OC_DIS    = {2'h0, RPC_IDX_OC_DIS, 2'h0};
    localparam logic [11:0] RPC_ADDR_FAULT_REC = {2'h0, RPC_IDX_FAULT_REC, 2'h0};
    localparam logic [11:0] RPC_ADDR_UNLOCK    = {2'h0, RPC_IDX_UNLOCK, 2'h0};

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          RPC_NUM_RAILS      = 5;
    localparam int          RPC_FB_LSB         = 3;   // Rail one at bit 7, rail five at bit 3.
    localparam int          RPC_SUP_LSB        = 1;   // Linear output at bit 1.
    localparam int          RPC_NUM_OVUV       = 7;   // Input, five rails, linear output.
    localparam int          RPC_NUM_OC         = 6;   // Five rails, linear output.
    localparam int          RPC_REC_UV_LSB     = 8;
    localparam int          RPC_REC_OC_LSB     = 16;
    localparam logic [7:0]  RPC_RST_BYTE       = 8'h00;
    localparam logic [7:0]  RPC_UNLOCK_KEY     = 8'hA5;

    // ------------------------------------------------------------------
    // Rail voltage scale in millivolts
    // ------------------------------------------------------------------
    localparam int          RPC_MV_W           = 12;
    localparam int          RPC_MIN_MV         = 300;
    localparam int          RPC_FULL_MAX_MV    = 2100;
    localparam int          RPC_FULL_STEP_MV   = 10;
    localparam int          RPC_HALF_MAX_MV    = 3460;
    localparam int          RPC_HALF_STEP_MV   = 20;
    localparam int          RPC_FULL_MAX_CODE  = (RPC_FULL_MAX_MV - RPC_MIN_MV) / RPC_FULL_STEP_MV;
    localparam int          RPC_HALF_MAX_CODE  = (RPC_HALF_MAX_MV - RPC_MIN_MV) / RPC_HALF_STEP_MV;

endpackage

// File: rpc_rail_scale.sv
/*
 * Converts one buck rail's voltage code into the output target and the
 * voltage seen at the feedback node, following the divider select bit.
 * Assumes code and select are synchronous to clk_sys_i; results lag by one clock.
 */
`timescale 1ns/1ns
module rpc_rail_scale #(
    parameter int CODE_W = 8
) (
    input  wire logic                        clk_sys_i,
    input  wire logic                        srst_i,
    input  wire logic                        div_sel_i,
    input  wire logic [CODE_W-1:0]           code_i,
    output logic      [rpc_pkg::RPC_MV_W-1:0] rail_output_voltage_mv_o,
    output logic      [rpc_pkg::RPC_MV_W-1:0] fb_mv_o
);
    import rpc_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (CODE_W < 8 || CODE_W > 16) begin : g_bad_width
        $error("rpc_rail_scale: CODE_W must lie between 8 and 16");
    end

    logic [RPC_MV_W-1:0] rail_output_voltage_d;
    logic [RPC_MV_W-1:0] fb_d;
    logic [RPC_MV_W-1:0] rail_output_voltage_q;
    logic [RPC_MV_W-1:0] fb_q;
    logic [15:0]         code_c;

    // Codes beyond the range clamp to the top step rather than wrapping.
    always_comb begin
        code_c = 16'(code_i);
        if (div_sel_i) begin
            if (code_c > 16'(RPC_HALF_MAX_CODE)) begin
                code_c = 16'(RPC_HALF_MAX_CODE);
            end
            rail_output_voltage_d = RPC_MV_W'(RPC_MIN_MV + 32'(code_c) * RPC_HALF_STEP_MV);
            fb_d   = {1'b0, rail_output_voltage_d[RPC_MV_W-1:1]};
        end else begin
            if (code_c > 16'(RPC_FULL_MAX_CODE)) begin
                code_c = 16'(RPC_FULL_MAX_CODE);
            end
            rail_output_voltage_d = RPC_MV_W'(RPC_MIN_MV + 32'(code_c) * RPC_FULL_STEP_MV);
            fb_d   = rail_output_voltage_d;
        end
    end

    // Results are registered so the data outputs come from flip-flops.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rail_output_voltage_q <= 12'h000;
            fb_q   <= 12'h000;
        end else begin
            rail_output_voltage_q <= rail_output_voltage_d;
            fb_q   <= fb_d;
        end
    end

    assign rail_output_voltage_mv_o = rail_output_voltage_q;
    assign fb_mv_o   = fb_q;

endmodule

// File: rpc_fault_gate.sv
/*
 * Gates a group of raw fault flags with their disable bits, registers the
 * action flags and keeps a sticky record that software clears by writing one.
 * Assumes raw flags are synchronous to clk_sys_i.
 */
`timescale 1ns/1ns
module rpc_fault_gate #(
    parameter int N = 7
) (
    input  wire logic         clk_sys_i,
    input  wire logic         srst_i,
    input  wire logic [N-1:0] raw_i,
    input  wire logic [N-1:0] dis_i,
    input  wire logic [N-1:0] clr_i,
    output logic      [N-1:0] act_o,
    output logic      [N-1:0] rec_o
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (N < 1 || N > 8) begin : g_bad_n
        $error("rpc_fault_gate: N must lie between 1 and 8");
    end

    logic [N-1:0] act_d;
    logic [N-1:0] act_q;
    logic [N-1:0] rec_d;
    logic [N-1:0] rec_q;

    always_comb begin
        act_d = raw_i & ~dis_i;
        rec_d = (rec_q & ~clr_i) | act_d;  // A new fault beats a clear in the same cycle.
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            act_q <= '0;
            rec_q <= '0;
        end else begin
            act_q <= act_d;
            rec_q <= rec_d;
        end
    end

    assign act_o = act_q;
    assign rec_o = rec_q;

endmodule

// File: rpc_config_regs.sv
/*
 * APB register bank for rail feedback ratio selection and per-supply
 * protection disables, with the rail scale converters and fault gating.
 * Assumes an APB master on clk_sys_i and fault flags synchronous to it.
 */
// Notes on behaviour
// - Rail select bits at 7..3, reserved 2..0; writes need test-mode unlock.
// - Select bit zero: feedback equals output, 0.3 to 2.1 V, 10 mV steps.
// - Select bit one: feedback is half output, 0.3 to 3.46 V, 20 mV steps.
// - Overvoltage disable: bit 7 input, 6..2 rails, 1 linear output, 0 reserved.
// - Overvoltage bit zero keeps protection active; one turns it off.
// - Undervoltage disable shares that map; zero active, one off; bit 0 reserved.
// - Overcurrent disable: 6..2 rails, 1 linear output; 7 and 0 reserved.
// - Overcurrent bit one turns off both cycle limit and protection together; the code has no cycle limit, it clears oc_protect_en_o and masks oc_trip_o.
`timescale 1ns/1ns
module rpc_config_regs #(
    parameter int CODE_W = 8
) (
    input  wire logic                                 clk_sys_i,
    input  wire logic                                 srst_i,
    input  wire logic [rpc_pkg::RPC_ADDR_W-1:0]       paddr_i,
    input  wire logic                                 psel_i,
    input  wire logic                                 penable_i,
    input  wire logic                                 pwrite_i,
    input  wire logic [31:0]                          pwdata_i,
    input  wire logic [3:0]                           pstrb_i,
    output logic      [31:0]                          prdata_o,
    output logic                                      pready_o,
    output logic                                      pslverr_o,
    input  wire logic [rpc_pkg::RPC_NUM_RAILS*CODE_W-1:0] rail_code_i,
    input  wire logic [rpc_pkg::RPC_NUM_OVUV-1:0]     ov_fault_raw_i,
    input  wire logic [rpc_pkg::RPC_NUM_OVUV-1:0]     uv_fault_raw_i,
    input  wire logic [rpc_pkg::RPC_NUM_OC-1:0]       oc_fault_raw_i,
    output logic      [rpc_pkg::RPC_NUM_RAILS-1:0]    rail_divider_select_o,
    output logic      [rpc_pkg::RPC_NUM_RAILS*rpc_pkg::RPC_MV_W-1:0] rail_output_mv_o,
    output logic      [rpc_pkg::RPC_NUM_RAILS*rpc_pkg::RPC_MV_W-1:0] rail_feedback_mv_o,
    output logic      [rpc_pkg::RPC_NUM_OVUV-1:0]     ov_protect_en_o,
    output logic      [rpc_pkg::RPC_NUM_OVUV-1:0]     uv_protect_en_o,
    output logic      [rpc_pkg::RPC_NUM_OC-1:0]       oc_protect_en_o,
    output logic      [rpc_pkg::RPC_NUM_OVUV-1:0]     ov_trip_o,
    output logic      [rpc_pkg::RPC_NUM_OVUV-1:0]     uv_trip_o,
    output logic      [rpc_pkg::RPC_NUM_OC-1:0]       oc_trip_o,
    output logic                                      test_unlocked_o
);
    import rpc_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (CODE_W < 8 || CODE_W > 16) begin : g_bad_width
        $error("rpc_config_regs: CODE_W must lie between 8 and 16");
    end

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic        wr_acc;
    logic        rd_setup;
    logic        hit_fb;
    logic        hit_ov;
    logic        hit_uv;
    logic        hit_oc;
    logic        hit_rec;
    logic        hit_key;
    logic        mapped;

    // Every register answers at once, so pready stays high.
    always_comb begin
        wr_acc   = psel_i && penable_i && pwrite_i;
        rd_setup = psel_i && !penable_i && !pwrite_i;
        hit_fb   = (paddr_i == RPC_ADDR_FB_RATIO);
        hit_ov   = (paddr_i == RPC_ADDR_OV_DIS);
        hit_uv   = (paddr_i == RPC_ADDR_UV_DIS);
        hit_oc   = (paddr_i == RPC_ADDR_OC_DIS);
        hit_rec  = (paddr_i == RPC_ADDR_FAULT_REC);
        hit_key  = (paddr_i == RPC_ADDR_UNLOCK);
        mapped   = hit_fb || hit_ov || hit_uv || hit_oc || hit_rec || hit_key;
    end

    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic [7:0] fb_ratio_d;
    logic [7:0] fb_ratio_q;
    logic [7:0] ov_dis_d;
    logic [7:0] ov_dis_q;
    logic [7:0] uv_dis_d;
    logic [7:0] uv_dis_q;
    logic [7:0] oc_dis_d;
    logic [7:0] oc_dis_q;
    logic       unlock_d;
    logic       unlock_q;

    // Only byte lane 0 carries these registers; a write with that lane
    // off is accepted on the bus and changes nothing.
    always_comb begin
        fb_ratio_d = fb_ratio_q;
        ov_dis_d   = ov_dis_q;
        uv_dis_d   = uv_dis_q;
        oc_dis_d   = oc_dis_q;
        unlock_d   = unlock_q;
        if (wr_acc && pstrb_i[0]) begin
            if (hit_fb && unlock_q) begin
                fb_ratio_d = pwdata_i[7:0];
            end
            if (hit_ov) begin
                ov_dis_d = pwdata_i[7:0];
            end
            if (hit_uv) begin
                uv_dis_d = pwdata_i[7:0];
            end
            if (hit_oc) begin
                oc_dis_d = pwdata_i[7:0];
            end
            // Any value other than the key closes the lock again.
            if (hit_key) begin
                unlock_d = (pwdata_i[7:0] == RPC_UNLOCK_KEY);
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            fb_ratio_q <= RPC_RST_BYTE;
            ov_dis_q   <= RPC_RST_BYTE;
            uv_dis_q   <= RPC_RST_BYTE;
            oc_dis_q   <= RPC_RST_BYTE;
            unlock_q   <= 1'b0;
        end else begin
            fb_ratio_q <= fb_ratio_d;
            ov_dis_q   <= ov_dis_d;
            uv_dis_q   <= uv_dis_d;
            oc_dis_q   <= oc_dis_d;
            unlock_q   <= unlock_d;
        end
    end

    // ------------------------------------------------------------------
    // Protection enables
    // ------------------------------------------------------------------
    // zero keeps overvoltage.
    assign ov_protect_en_o = ~ov_dis_q[7:RPC_SUP_LSB];
    assign uv_protect_en_o = ~uv_dis_q[7:RPC_SUP_LSB];
    assign oc_protect_en_o = ~oc_dis_q[6:RPC_SUP_LSB];
    assign rail_divider_select_o = fb_ratio_q[7:RPC_FB_LSB];
    assign test_unlocked_o       = unlock_q;

    // ------------------------------------------------------------------
    // Rail scale converters
    // ------------------------------------------------------------------
    // Bit 7 is rail one, so the select vector is reversed per rail index.
    for (genvar r = 0; r < RPC_NUM_RAILS; r++) begin : g_rail
        rpc_rail_scale #(
            .CODE_W    (CODE_W)
        ) u_scale (
            .clk_sys_i (clk_sys_i),
            .srst_i    (srst_i),
            .div_sel_i (fb_ratio_q[7-r]),
            .code_i    (rail_code_i[r*CODE_W +: CODE_W]),
            .rail_output_voltage_mv_o (rail_output_mv_o[r*RPC_MV_W +: RPC_MV_W]),
            .fb_mv_o   (rail_feedback_mv_o[r*RPC_MV_W +: RPC_MV_W])
        );
    end

    // ------------------------------------------------------------------
    // Fault gating and record
    // ------------------------------------------------------------------
    logic [RPC_NUM_OVUV-1:0] ov_clr;
    logic [RPC_NUM_OVUV-1:0] uv_clr;
    logic [RPC_NUM_OC-1:0]   oc_clr;
    logic [RPC_NUM_OVUV-1:0] ov_rec;
    logic [RPC_NUM_OVUV-1:0] uv_rec;
    logic [RPC_NUM_OC-1:0]   oc_rec;

    // Writing one to a record bit clears it; each kind has its own lane.
    always_comb begin
        ov_clr = '0;
        uv_clr = '0;
        oc_clr = '0;
        if (wr_acc && hit_rec) begin
            ov_clr = pstrb_i[0] ? pwdata_i[RPC_NUM_OVUV-1:0] : '0;
            uv_clr = pstrb_i[1] ? pwdata_i[RPC_REC_UV_LSB +: RPC_NUM_OVUV] : '0;
            oc_clr = pstrb_i[2] ? pwdata_i[RPC_REC_OC_LSB +: RPC_NUM_OC] : '0;
        end
    end

    rpc_fault_gate #(.N(RPC_NUM_OVUV)) u_ov_gate (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .raw_i     (ov_fault_raw_i),
        .dis_i     (ov_dis_q[7:RPC_SUP_LSB]),
        .clr_i     (ov_clr),
        .act_o     (ov_trip_o),
        .rec_o     (ov_rec)
    );

    rpc_fault_gate #(.N(RPC_NUM_OVUV)) u_uv_gate (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .raw_i     (uv_fault_raw_i),
        .dis_i     (uv_dis_q[7:RPC_SUP_LSB]),
        .clr_i     (uv_clr),
        .act_o     (uv_trip_o),
        .rec_o     (uv_rec)
    );

    rpc_fault_gate #(.N(RPC_NUM_OC)) u_oc_gate (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .raw_i     (oc_fault_raw_i),
        .dis_i     (oc_dis_q[6:RPC_SUP_LSB]),
        .clr_i     (oc_clr),
        .act_o     (oc_trip_o),
        .rec_o     (oc_rec)
    );

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [31:0] prdata_d;
    logic [31:0] prdata_q;

    // Read data is captured in the setup cycle so it stands registered
    // through the access cycle; it holds otherwise to save toggling.
    always_comb begin
        prdata_d = prdata_q;
        if (rd_setup) begin
            prdata_d = 32'h0000_0000;
            if (hit_fb) begin
                prdata_d[7:0] = fb_ratio_q;
            end
            if (hit_ov) begin
                prdata_d[7:0] = ov_dis_q;
            end
            if (hit_uv) begin
                prdata_d[7:0] = uv_dis_q;
            end
            if (hit_oc) begin
                prdata_d[7:0] = oc_dis_q;
            end
            if (hit_rec) begin
                prdata_d[RPC_NUM_OVUV-1:0]                 = ov_rec;
                prdata_d[RPC_REC_UV_LSB +: RPC_NUM_OVUV]  = uv_rec;
                prdata_d[RPC_REC_OC_LSB +: RPC_NUM_OC]    = oc_rec;
            end
            if (hit_key) begin
                prdata_d[0] = unlock_q;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            prdata_q <= 32'h0000_0000;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    assign prdata_o = prdata_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    chk_fb_lock_hold: assert property (
        (wr_acc && hit_fb && !unlock_q) |=> $stable(fb_ratio_q))
        else $error("ratio register changed while locked");

    chk_fb_write_take: assert property (
        (wr_acc && hit_fb && unlock_q && pstrb_i[0])
        |=> (rail_divider_select_o == $past(pwdata_i[7:3])))
        else $error("unlocked ratio write not taken");

    chk_fb_full_scale: assert property (
        (!rail_divider_select_o[4])[*2]
        |-> (rail_feedback_mv_o[11:0] == rail_output_mv_o[11:0])
            && (rail_output_mv_o[11:0] <= 12'h834))
        else $error("full scale feedback or range wrong");

    chk_fb_half_scale: assert property (
        (rail_divider_select_o[4])[*2]
        |-> ({rail_feedback_mv_o[10:0], 1'b0} == rail_output_mv_o[11:0])
            && (rail_output_mv_o[11:0] <= 12'hD84))
        else $error("half scale feedback or range wrong");

    chk_ov_enable_map: assert property (
        (wr_acc && hit_ov && pstrb_i[0]) |=> (ov_protect_en_o == ~$past(pwdata_i[7:1])))
        else $error("overvoltage enables do not follow write");

    chk_uv_enable_map: assert property (
        (wr_acc && hit_uv && pstrb_i[0]) |=> (uv_protect_en_o == ~$past(pwdata_i[7:1])))
        else $error("undervoltage enables do not follow write");

    chk_oc_enable_map: assert property (
        (wr_acc && hit_oc && pstrb_i[0]) |=> (oc_protect_en_o == ~$past(pwdata_i[6:1])))
        else $error("overcurrent enables do not follow write");

    chk_input_ov_mask: assert property (
        (ov_dis_q[7] && ov_fault_raw_i[6]) |=> (!ov_trip_o[6] && !$rose(ov_rec[6])))
        else $error("disabled input overvoltage acted or recorded");

    chk_oc_fault_mask: assert property (
        oc_dis_q[1] |=> !oc_trip_o[0])
        else $error("disabled linear overcurrent acted");

    chk_record_sticky: assert property (
        (uv_fault_raw_i[0] && !uv_dis_q[1]) |=> uv_rec[0])
        else $error("enabled undervoltage fault not recorded");

    cov_unlock_write: cover property (
        unlock_q && wr_acc && hit_fb ##1 rail_divider_select_o != 5'h00);
    cov_ov_trip: cover property (ov_trip_o != 7'h00);
    cov_half_scale: cover property (rail_divider_select_o[4][*2]);
    cov_rec_clear: cover property (wr_acc && hit_rec ##1 oc_rec == 6'h00);

endmodule

// File: rpc_config_regs_bench.sv
/*
 * Self-checking bench for the rail protection configuration register bank.
 * Assumes the design answers APB with pready and keeps the notes' latencies.
 */
`timescale 1ns/1ns
module rpc_config_regs_bench;
    import rpc_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        clk, rst, psel, pen, pwr, pready, pslverr, unl, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, m_rec;
    logic [3:0]  pstrb, st;
    logic [39:0] code;
    logic [6:0]  ovr, uvr, ov_en, uv_en, ov_tr, uv_tr;
    logic [5:0]  ocr, oc_en, oc_tr;
    logic [4:0]  dsel;
    logic [59:0] vmv, fmv;
    logic [7:0]  m_fb, m_ov, m_uv, m_oc, b;
    int          err_total, compares, v, c;

    rpc_config_regs dut (.clk_sys_i(clk), .srst_i(rst), .paddr_i(paddr), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rail_code_i(code),
        .ov_fault_raw_i(ovr), .uv_fault_raw_i(uvr), .oc_fault_raw_i(ocr),
        .rail_divider_select_o(dsel), .rail_output_mv_o(vmv), .rail_feedback_mv_o(fmv),
        .ov_protect_en_o(ov_en), .uv_protect_en_o(uv_en), .oc_protect_en_o(oc_en),
        .ov_trip_o(ov_tr), .uv_trip_o(uv_tr), .oc_trip_o(oc_tr), .test_unlocked_o(unl));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // Compare one value and count it.
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One APB transfer; the request stands until pready is seen high.
    // An idle edge follows, so a following call never re-drives psel in one step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d; pstrb <= st;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) err_total++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask

    // Read a register and compare data and error flag.
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
        chk({31'h0, er}, 32'h0);
    endtask

    task automatic close_out;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Six iterations need far fewer than this many cycles.
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        close_out;
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 12'h0; pwdata = 32'h0;
        pstrb = 4'h0; code = 40'h0; ovr = 7'h0; uvr = 7'h0; ocr = 6'h0;
        err_total = 0; compares = 0; m_fb = 8'h0; m_ov = 8'h0; m_uv = 8'h0; m_oc = 8'h0;
        m_rec = 32'h0;
        st = 4'hF;
        void'($urandom(32'h647F));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rdchk(RPC_ADDR_FB_RATIO, 32'h0);
        rdchk(RPC_ADDR_OV_DIS, 32'h0);
        rdchk(RPC_ADDR_UV_DIS, 32'h0);
        rdchk(RPC_ADDR_OC_DIS, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        chk({31'h0, unl}, 32'h0);
        // A write with byte lane 0 off must leave the register alone.
        st = 4'hE;
        apb(1'b1, RPC_ADDR_OV_DIS, 32'hFF);
        st = 4'hF;
        rdchk(RPC_ADDR_OV_DIS, 32'h0);
        $display("test reset and unmapped done");
        for (int i = 0; i < 6; i++) begin
            b = 8'($urandom); m_ov = 8'($urandom); m_uv = 8'($urandom); m_oc = 8'($urandom);
            apb(1'b1, RPC_ADDR_FB_RATIO, {24'h0, b});
            rdchk(RPC_ADDR_FB_RATIO, {24'h0, m_fb});
            apb(1'b1, RPC_ADDR_UNLOCK, {24'h0, RPC_UNLOCK_KEY});
            rdchk(RPC_ADDR_UNLOCK, 32'h1);
            chk({31'h0, unl}, 32'h1);
            apb(1'b1, RPC_ADDR_FB_RATIO, {24'h0, b});
            m_fb = b;
            rdchk(RPC_ADDR_FB_RATIO, {24'h0, m_fb});
            apb(1'b1, RPC_ADDR_UNLOCK, 32'h0);
            apb(1'b1, RPC_ADDR_OV_DIS, {24'h0, m_ov});
            apb(1'b1, RPC_ADDR_UV_DIS, {24'h0, m_uv});
            apb(1'b1, RPC_ADDR_OC_DIS, {24'h0, m_oc});
            rdchk(RPC_ADDR_UNLOCK, 32'h0);
            chk({31'h0, unl}, 32'h0);
            rdchk(RPC_ADDR_OV_DIS, {24'h0, m_ov});
            rdchk(RPC_ADDR_UV_DIS, {24'h0, m_uv});
            rdchk(RPC_ADDR_OC_DIS, {24'h0, m_oc});
            // Full 8-bit codes, so the top-step clamps of both scales are reached.
            code <= {$urandom, 8'($urandom)};
            @(posedge clk);
            ovr <= 7'($urandom); uvr <= 7'($urandom); ocr <= 6'($urandom);
            @(posedge clk);
            @(negedge clk);
            chk(dsel, m_fb[7:3]);
            chk(ov_en, {~m_ov[7:1]});
            chk(uv_en, {~m_uv[7:1]});
            chk(oc_en, {~m_oc[6:1]});
            chk(ov_tr, {ovr & ~m_ov[7:1]});
            chk(uv_tr, {uvr & ~m_uv[7:1]});
            chk(oc_tr, {ocr & ~m_oc[6:1]});
            for (int r = 0; r < 5; r++) begin
                c = int'(code[r*8+:8]);
                if (m_fb[7-r] && c > RPC_HALF_MAX_CODE) c = RPC_HALF_MAX_CODE;
                if (!m_fb[7-r] && c > RPC_FULL_MAX_CODE) c = RPC_FULL_MAX_CODE;
                v = m_fb[7-r] ? 300 + 20 * c : 300 + 10 * c;
                chk(vmv[r*12+:12], v);
                chk(fmv[r*12+:12], m_fb[7-r] ? v / 2 : v);
            end
            m_rec = {10'h0, ocr & ~m_oc[6:1], 1'b0, uvr & ~m_uv[7:1], 1'b0, ovr & ~m_ov[7:1]};
            @(posedge clk);
            rdchk(RPC_ADDR_FAULT_REC, m_rec);
            ovr <= 7'h0; uvr <= 7'h0; ocr <= 6'h0;
            @(posedge clk);
            @(posedge clk);
            apb(1'b1, RPC_ADDR_FAULT_REC, 32'h00FFFFFF);
            rdchk(RPC_ADDR_FAULT_REC, 32'h0);
            $display("test iteration %0d done", i);
        end
        close_out;
    end

endmodule
